/* pkg/ddr_mode_pkg.sv */
package ddr_mode_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int          addr_width          = 12;
   localparam logic [11:0] mode_command_offset = 12'h000;
   localparam logic [11:0] control_offset      = 12'h004;

   // Only implemented bits are stored, so reserved bits read as zero.
   localparam logic [31:0] mode_command_mask   = 32'hfffd_0000;
   localparam logic [31:0] control_mask        = 32'hd33f_8c06;
   localparam logic [31:0] mode_command_reset  = 32'h0000_0000;
   localparam logic [31:0] control_reset       = 32'h0000_0000;

   // ****************************************************************
   // Mode command fields
   // ****************************************************************
   localparam int mode_bank_hi         = 31;
   localparam int mode_bank_lo         = 30;
   localparam int mode_opcode_hi       = 29;
   localparam int mode_opcode_lo       = 18;
   localparam int operating_variant_hi = 29;
   localparam int operating_variant_lo = 25;
   localparam int read_latency_hi      = 24;
   localparam int read_latency_lo      = 22;
   localparam int burst_order_bit      = 21;
   localparam int burst_size_hi        = 20;
   localparam int burst_size_lo        = 18;
   localparam int mode_trigger_bit     = 16;

   // ****************************************************************
   // Control fields
   // ****************************************************************
   localparam int mode_write_en_bit    = 31;
   localparam int clock_gate_bit       = 30;
   localparam int auto_refresh_bit     = 28;
   localparam int address_split_hi     = 25;
   localparam int address_split_lo     = 24;
   localparam int refresh_interval_hi  = 21;
   localparam int refresh_interval_lo  = 16;
   localparam int strobe_bypass_bit    = 15;
   localparam int strobe_oe_hi         = 11;
   localparam int strobe_oe_lo         = 10;
   localparam int single_refresh_bit   = 2;
   localparam int precharge_bit        = 1;

   // ****************************************************************
   // Timing and command codes
   // ****************************************************************
   localparam int refresh_unit_clocks  = 64;
   localparam int refresh_count_width  = 13;

   typedef enum logic [2:0] {
      cmd_mode_load = 3'h1,
      cmd_precharge = 3'h2,
      cmd_refresh   = 3'h4
   } command_t;

endpackage

/* design/ddr_mode_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// - mode load waits for dummy memory access
// - bank select drives bank lines on load
// - operating variant sent as operating mode
// - read latency field sent as latency
// - burst order and size sent on load
// - load trigger arms a mode load
// - mode writes blocked when write enable clear
// - auto refresh enable issues periodic refreshes
// - address split field selects address mapping
// - refresh every (interval+1) times 64 clocks
// - bypass clear selects strobe recovered clock
// - strobe enable field drives strobe pins
// - refresh trigger zero issues no refresh
// - precharge trigger zero issues no precharge
// - precharge armed, issued on dummy access
// - refresh trigger write issues one refresh
// - mode writes accepted when write enable set
module ddr_mode_ctrl (
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [ddr_mode_pkg::addr_width-1:0] paddr,
   input  wire logic [31:0]                         pwdata,
   output logic      [31:0]                         prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire logic                                memory_clock,
   input  wire logic                                dummy_access,
   output logic                                     cmd_valid,
   output logic      [2:0]                          cmd_code,
   output logic      [1:0]                          mode_bank_select,
   output logic      [11:0]                         mode_opcode,
   output logic                                     memory_clock_gate_pin,
   output logic      [1:0]                          memory_strobe_oe,
   output logic                                     strobe_clock_bypass,
   output logic                                     read_clock_recovered,
   output logic      [1:0]                          address_split_select
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [31:0] mode_cmd;
      logic [31:0] control;
      logic        mode_fire;
      logic        precharge_every_bank_command_fire;
      logic        ref_pending;
      logic        auto_pending;
      logic [ddr_mode_pkg::refresh_count_width-1:0] ref_count;
      logic [2:0]  clk_sync;
      logic        cmd_valid;
      logic [2:0]  cmd_code;
      logic [1:0]  bank;
      logic [11:0] opcode;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic                                          mem_edge;
   logic                                          setup_phase;
   logic                                          write_taken;
   logic                                          hit_mode;
   logic                                          hit_control;
   logic [5:0]                                    interval;
   logic [ddr_mode_pkg::refresh_count_width-1:0]  refresh_limit;

   // The memory clock comes from another domain; the first stage is
   // read only by the second, and edges are found on stages two and
   // three. Commands are therefore issued up to three pclk cycles
   // after the memory clock edge.
   assign mem_edge    = state_reg.clk_sync[1] & ~state_reg.clk_sync[2];
   assign setup_phase = psel & ~penable;
   assign write_taken = psel & penable & state_reg.ready & pwrite;
   assign hit_mode    = (paddr == ddr_mode_pkg::mode_command_offset);
   assign hit_control = (paddr == ddr_mode_pkg::control_offset);
   assign interval    = state_reg.control[
                           ddr_mode_pkg::refresh_interval_hi:
                           ddr_mode_pkg::refresh_interval_lo];
   assign refresh_limit = ddr_mode_pkg::refresh_count_width'(
      (int'(interval) + 1) * ddr_mode_pkg::refresh_unit_clocks - 1);

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      state_next           = state_reg;
      state_next.cmd_valid = 1'b0;
      state_next.clk_sync  = {state_reg.clk_sync[1:0], memory_clock};

      // APB: zero wait states, the answer is ready in the access phase.
      state_next.ready  = setup_phase;
      state_next.slverr = setup_phase & ~(hit_mode | hit_control);
      state_next.rdata  = 32'h0000_0000;
      if (setup_phase && !pwrite) begin
         if (hit_mode) begin
            state_next.rdata = state_reg.mode_cmd;
         end else if (hit_control) begin
            state_next.rdata = state_reg.control;
         end
      end

      // Command issue, one per memory clock edge. Precharge goes first
      // so that a combined dummy access closes rows before a mode load.
      if (mem_edge) begin
         if (state_reg.precharge_every_bank_command_fire) begin
            state_next.cmd_valid = 1'b1;
            state_next.cmd_code  = ddr_mode_pkg::cmd_precharge;
            state_next.precharge_every_bank_command_fire = 1'b0;
            state_next.control[ddr_mode_pkg::precharge_bit] = 1'b0;
         end else if (state_reg.mode_fire) begin
            state_next.cmd_valid = 1'b1;
            state_next.cmd_code  = ddr_mode_pkg::cmd_mode_load;
            state_next.bank      = state_reg.mode_cmd[
                                      ddr_mode_pkg::mode_bank_hi:
                                      ddr_mode_pkg::mode_bank_lo];
            // Operating variant, latency, burst order and size.
            state_next.opcode    = state_reg.mode_cmd[
                                      ddr_mode_pkg::mode_opcode_hi:
                                      ddr_mode_pkg::mode_opcode_lo];
            state_next.mode_fire = 1'b0;
            state_next.mode_cmd[ddr_mode_pkg::mode_trigger_bit] =
               1'b0;
         end else if (state_reg.ref_pending) begin
            state_next.cmd_valid   = 1'b1;
            state_next.cmd_code    = ddr_mode_pkg::cmd_refresh;
            state_next.ref_pending = 1'b0;
            state_next.control[ddr_mode_pkg::single_refresh_bit] =
               1'b0;
         end else if (state_reg.auto_pending) begin
            state_next.cmd_valid    = 1'b1;
            state_next.cmd_code     = ddr_mode_pkg::cmd_refresh;
            state_next.auto_pending = 1'b0;
         end

         // Periodic refresh timer counts memory clocks. A request that
         // matures while an older one waits is merged with it.
         if (state_reg.control[ddr_mode_pkg::auto_refresh_bit]) begin
            if (state_reg.ref_count >= refresh_limit) begin
               state_next.ref_count    = '0;
               state_next.auto_pending = 1'b1;
            end else begin
               state_next.ref_count = state_reg.ref_count + 1'b1;
            end
         end
      end
      if (!state_reg.control[ddr_mode_pkg::auto_refresh_bit]) begin
         state_next.ref_count    = '0;
         state_next.auto_pending = 1'b0;
      end

      // A dummy access to memory space releases the armed commands. The
      // trigger is read after this cycle's self clear, so an access that
      // meets the issue of the same command does not send it twice.
      if (dummy_access) begin
         if (state_next.mode_cmd[ddr_mode_pkg::mode_trigger_bit]) begin
            state_next.mode_fire = 1'b1;
         end
         if (state_next.control[ddr_mode_pkg::precharge_bit]) begin
            state_next.precharge_every_bank_command_fire = 1'b1;
         end
      end

      // Register writes come last so that a new trigger wins over the
      // self clear of the command issued in the same cycle.
      if (write_taken && hit_mode &&
          state_reg.control[
             ddr_mode_pkg::mode_write_en_bit]) begin
         state_next.mode_cmd = pwdata & ddr_mode_pkg::mode_command_mask;
      end
      if (write_taken && hit_control) begin
         state_next.control = pwdata & ddr_mode_pkg::control_mask;
         if (pwdata[ddr_mode_pkg::single_refresh_bit]) begin
            state_next.ref_pending = 1'b1;
         end else if (state_next.ref_pending) begin
            // Keep the bit visible until the earlier refresh is sent.
            state_next.control[ddr_mode_pkg::single_refresh_bit] = 1'b1;
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg          <= '0;
         state_reg.mode_cmd <= ddr_mode_pkg::mode_command_reset;
         state_reg.control  <= ddr_mode_pkg::control_reset;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata                = state_reg.rdata;
   assign pready                = state_reg.ready;
   assign pslverr               = state_reg.slverr;
   assign cmd_valid             = state_reg.cmd_valid;
   assign cmd_code              = state_reg.cmd_code;
   assign mode_bank_select      = state_reg.bank;
   assign mode_opcode           = state_reg.opcode;
   assign memory_clock_gate_pin =
      state_reg.control[ddr_mode_pkg::clock_gate_bit];
   assign memory_strobe_oe      = state_reg.control[
      ddr_mode_pkg::strobe_oe_hi:ddr_mode_pkg::strobe_oe_lo];
   assign strobe_clock_bypass   =
      state_reg.control[ddr_mode_pkg::strobe_bypass_bit];
   // The strobe-recovered read clock is used unless bypass is set.
   assign read_clock_recovered  =
      ~state_reg.control[ddr_mode_pkg::strobe_bypass_bit];
   assign address_split_select  = state_reg.control[
      ddr_mode_pkg::address_split_hi:ddr_mode_pkg::address_split_lo];

   // ****************************************************************
   // Checks
   // ****************************************************************
   // Only the self clear of the trigger may touch a locked register.
   localparam logic [31:0] trigger_mask =
      32'h1 << ddr_mode_pkg::mode_trigger_bit;

   a_mode_lock: assert property (
      @(posedge pclk) disable iff (!presetn)
      (write_taken && hit_mode &&
       !state_reg.control[ddr_mode_pkg::mode_write_en_bit])
      |=> ((state_reg.mode_cmd | trigger_mask) ==
           ($past(state_reg.mode_cmd) | trigger_mask)) &&
          !$rose(state_reg.mode_cmd[ddr_mode_pkg::mode_trigger_bit]))
      else $error("mode command changed while writes were locked");

   a_mode_accept: assert property (
      @(posedge pclk) disable iff (!presetn)
      (write_taken && hit_mode &&
       state_reg.control[ddr_mode_pkg::mode_write_en_bit])
      |=> (state_reg.mode_cmd ==
           ($past(pwdata) & ddr_mode_pkg::mode_command_mask)))
      else $error("enabled mode command write was not stored");

   a_mode_dummy: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(state_reg.mode_fire) |-> $past(dummy_access))
      else $error("mode load released without a dummy access");

   a_precharge_every_bank_command_dummy: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(state_reg.precharge_every_bank_command_fire) |-> $past(dummy_access) &&
      $past(state_reg.control[ddr_mode_pkg::precharge_bit]))
      else $error("precharge released without arming and access");

   a_mode_fields: assert property (
      @(posedge pclk) disable iff (!presetn)
      (state_reg.cmd_valid &&
       state_reg.cmd_code == ddr_mode_pkg::cmd_mode_load)
      |-> (state_reg.bank == $past(state_reg.mode_cmd[
              ddr_mode_pkg::mode_bank_hi:ddr_mode_pkg::mode_bank_lo])) &&
          (state_reg.opcode == $past(state_reg.mode_cmd[
              ddr_mode_pkg::mode_opcode_hi:ddr_mode_pkg::mode_opcode_lo])))
      else $error("mode load fields differ from the register");

   // A refresh may wait behind a precharge and a mode load, one memory
   // clock edge each, so the bound allows a few memory clock periods.
   a_ref_arm: assert property (
      @(posedge pclk) disable iff (!presetn)
      (write_taken && hit_control &&
       pwdata[ddr_mode_pkg::single_refresh_bit])
      |=> state_reg.ref_pending ##[1:40]
          (state_reg.cmd_valid &&
           state_reg.cmd_code == ddr_mode_pkg::cmd_refresh))
      else $error("refresh trigger write did not lead to a refresh");

   a_ref_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      (write_taken && hit_control && !pwdata[2] && !pwdata[28] &&
       !state_reg.ref_pending && !state_reg.auto_pending)
      |=> ##1 !(state_reg.cmd_valid &&
                state_reg.cmd_code == ddr_mode_pkg::cmd_refresh))
      else $error("refresh issued without a trigger");

   a_precharge_every_bank_command_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      (write_taken && hit_control && !pwdata[1] && !state_reg.precharge_every_bank_command_fire)
      |=> ##1 !(state_reg.cmd_valid &&
                state_reg.cmd_code == ddr_mode_pkg::cmd_precharge))
      else $error("precharge issued without a trigger");

   a_refresh_period: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(state_reg.auto_pending) |->
      ($past(state_reg.ref_count) >= $past(refresh_limit)) && $past(mem_edge))
      else $error("periodic refresh requested at wrong count");

   a_issue_edge: assert property (
      @(posedge pclk) disable iff (!presetn)
      state_reg.cmd_valid |-> $past(mem_edge))
      else $error("command issued away from a memory clock edge");

   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg.ready |=> !state_reg.ready)
      else $error("pready held for more than one cycle");

endmodule

/* testbench/ddr_memory_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Memory side: free running clock and command log
// ****************************************************************
module ddr_memory_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   output logic             memory_clock,
   input  wire logic        cmd_valid,
   input  wire logic [2:0]  cmd_code,
   input  wire logic [1:0]  mode_bank_select,
   input  wire logic [11:0] mode_opcode,
   output int               cmd_count,
   output logic [2:0]       last_code,
   output logic [1:0]       last_bank,
   output logic [11:0]      last_opcode,
   output time              last_time
);
   // The memory clock runs free; the odd offset keeps it out of phase.
   initial begin
      memory_clock = 1'b0;
      #13;
      forever #200 memory_clock = ~memory_clock;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_count   <= 0;
         last_code   <= 3'h0;
         last_bank   <= 2'h0;
         last_opcode <= 12'h000;
         last_time   <= 0;
      end else if (cmd_valid === 1'b1) begin
         cmd_count   <= cmd_count + 1;
         last_code   <= cmd_code;
         last_bank   <= mode_bank_select;
         last_opcode <= mode_opcode;
         last_time   <= $time;
      end
   end
endmodule

/* testbench/ddr_sdram_mode_and_init_control_tb.sv */
`timescale 1ns/1ps
module ddr_sdram_mode_and_init_control_tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        memory_clock;
   logic        dummy_access;
   logic        cmd_valid;
   logic [2:0]  cmd_code;
   logic [1:0]  bank;
   logic [11:0] opcode;
   logic        gate;
   logic [1:0]  oe;
   logic        bypass;
   logic        recov;
   logic [1:0]  split;
   int          cmd_count;
   logic [2:0]  last_code;
   logic [1:0]  last_bank;
   logic [11:0] last_opcode;
   time         last_time;
   int          mismatches;
   int          num_checks;
   localparam logic [11:0] mreg = ddr_mode_pkg::mode_command_offset;
   localparam logic [11:0] creg = ddr_mode_pkg::control_offset;

   ddr_mode_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .memory_clock(memory_clock), .dummy_access(dummy_access),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .mode_bank_select(bank),
      .mode_opcode(opcode), .memory_clock_gate_pin(gate),
      .memory_strobe_oe(oe), .strobe_clock_bypass(bypass),
      .read_clock_recovered(recov), .address_split_select(split));
   ddr_memory_model mem (.pclk(pclk), .presetn(presetn),
      .memory_clock(memory_clock), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .mode_bank_select(bank), .mode_opcode(opcode),
      .cmd_count(cmd_count), .last_code(last_code), .last_bank(last_bank),
      .last_opcode(last_opcode), .last_time(last_time));

   always #25 pclk = ~pclk;

   // ****************************************************************
   // Expectations and bus tasks
   // ****************************************************************
   function automatic logic [31:0] exp_mode(input logic [31:0] v);
      return v & ddr_mode_pkg::mode_command_mask & ~32'h0001_0000;
   endfunction
   function automatic logic [6:0] ctl_outs(input logic [31:0] v);
      return {v[30], v[25:24], v[11:10], v[15], ~v[15]};
   endfunction

   task automatic test_done();
      if (mismatches == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x,
                     input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk("read data", x, r);
      chk("slave error", {31'h0, xe}, {31'h0, e});
   endtask

   task automatic dummy();
      @(posedge pclk);
      dummy_access <= 1'b1;
      @(posedge pclk);
      dummy_access <= 1'b0;
   endtask

   task automatic expect_cmd(input logic [2:0] code, input int lim);
      int c0;
      int n;
      c0 = cmd_count;
      n = 0;
      while (cmd_count == c0 && n < lim) begin
         @(posedge pclk);
         n++;
      end
      chk("command count", c0 + 1, cmd_count);
      chk("command code", {29'h0, code}, {29'h0, last_code});
   endtask

   task automatic no_cmd();
      int c0;
      c0 = cmd_count;
      repeat (40) @(posedge pclk);
      chk("idle command count", c0, cmd_count);
   endtask

   task automatic mode_load(input logic [31:0] v);
      wr(mreg, v);
      no_cmd();
      dummy();
      expect_cmd(ddr_mode_pkg::cmd_mode_load, 60);
      chk("bank", {30'h0, v[31:30]}, {30'h0, last_bank});
      chk("opcode", {20'h0, v[29:18]},
          {20'h0, last_opcode});
      rd(mreg, exp_mode(v), 1'b0);
   endtask

   task automatic precharge();
      wr(creg, 32'hc109_0002);
      rd(creg, 32'hc109_0002, 1'b0);
      no_cmd();
      dummy();
      expect_cmd(ddr_mode_pkg::cmd_precharge, 60);
      rd(creg, 32'hc109_0000, 1'b0);
   endtask

   initial begin
      repeat (40000) @(posedge pclk);
      mismatches++;
      test_done();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [31:0] v;
      time         t0;
      time         d;
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, dummy_access} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      mismatches = 0;
      num_checks = 0;
      void'($urandom(32'ha5cc));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(mreg, 32'h0, 1'b0);
      rd(creg, 32'h0, 1'b0);
      rd(12'h008, 32'h0, 1'b1);
      wr(mreg, 32'h4001_0000);
      rd(mreg, 32'h0, 1'b0);
      dummy();
      no_cmd();
      precharge();
      mode_load(32'h4001_0000);
      mode_load(32'h049d_0000);
      precharge();
      repeat (2) begin
         wr(creg, 32'hc109_0004);
         expect_cmd(ddr_mode_pkg::cmd_refresh, 60);
         rd(creg, 32'hc109_0000, 1'b0);
      end
      repeat (4) begin
         v = ($urandom() & 32'hfffc_0000) | 32'h0001_0000;
         mode_load(v);
      end
      mode_load(32'h009d_0000);
      wr(creg, 32'h8200_8400);
      // The outputs change at the write edge; look one edge later.
      @(posedge pclk);
      chk("control outputs", ctl_outs(32'h8200_8400),
          {gate, split, oe, bypass, recov});
      no_cmd();
      dummy();
      no_cmd();
      v = 32'h5109_0c00;
      wr(creg, v);
      @(posedge pclk);
      chk("control outputs", ctl_outs(v),
          {gate, split, oe, bypass, recov});
      wr(mreg, 32'h0001_0000);
      dummy();
      rd(mreg, 32'h009c_0000, 1'b0);
      expect_cmd(ddr_mode_pkg::cmd_refresh, 6000);
      t0 = last_time;
      expect_cmd(ddr_mode_pkg::cmd_refresh, 6000);
      d = last_time - t0;
      chk("refresh gap ok", 32'h1,
          {31'h0, d >= (v[21:16] + 1) * 64 * 400 - 100 &&
                  d <= (v[21:16] + 1) * 64 * 400 + 100});
      test_done();
   end
endmodule
